// ==== hw/nbrc_top.sv ====
// Nested block-repeat control: two loop levels, mode handling and register slave
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
module nbrc_top (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    // Avalon-MM slave
    input  wire logic [8:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // CPU decode and program flow
    input  wire logic        rpt_start_i,
    input  wire logic [23:0] rpt_start_addr_i,
    input  wire logic [23:0] rpt_end_addr_i,
    input  wire logic        exec_valid_i,
    input  wire logic [23:0] exec_addr_i,
    input  wire logic        ctx_save_i,
    input  wire logic        ctx_restore_i,
    input  wire logic [1:0]  ctx_restore_val_i,
    output logic             redirect_o,
    output logic      [23:0] redirect_addr_o,
    output logic      [1:0]  level_active_o,
    output logic      [1:0]  flow_context_record_o,
    output logic             loop_active_flag_o,
    output logic             compat_mode_bit_o
);
    nbrc_level_if lvl0_if ();
    nbrc_level_if lvl1_if ();

    nbrc_pkg::nbrc_bus_state_t bus_state_r;
    nbrc_pkg::nbrc_bus_state_t bus_state_nxt;

    logic        waitreq_r;
    logic [31:0] rdata_r;
    logic [15:0] rd_mux;
    logic        flag_r;
    logic        flag_nxt;
    logic        mode_r;
    logic        mode_nxt;
    logic [1:0]  act_r;
    logic [1:0]  act_nxt;
    logic [1:0]  ctx_r;
    logic [1:0]  ctx_nxt;
    logic        redirect_r;
    logic [23:0] redirect_addr_r;

    // Address decode
    logic [nbrc_pkg::IDX_W-1:0] word_idx;
    logic        bus_req;
    logic        wr_commit;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        hit_status;

    assign word_idx   = avs_address_i[8:2];
    assign bus_req    = avs_read_i | avs_write_i;
    // A write lands only at the edge where the master sees waitrequest low
    assign wr_commit  = avs_write_i & (bus_state_r == nbrc_pkg::NBRC_BUS_ACK);
    assign wdata      = avs_writedata_i[15:0];
    assign be         = avs_byteenable_i[1:0];
    assign hit_status = (word_idx == nbrc_pkg::IDX_STATUS_ONE);

    assign lvl0_if.be          = be;
    assign lvl0_if.wdata       = wdata;
    assign lvl0_if.we_cnt      = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP0_CNT);
    assign lvl0_if.we_save     = 1'b0;
    assign lvl0_if.we_start_hi = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP0_START_HI);
    assign lvl0_if.we_start_lo = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP0_START_LO);
    assign lvl0_if.we_end_hi   = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP0_END_HI);
    assign lvl0_if.we_end_lo   = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP0_END_LO);

    assign lvl1_if.be          = be;
    assign lvl1_if.wdata       = wdata;
    assign lvl1_if.we_cnt      = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP1_CNT);
    assign lvl1_if.we_save     = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP1_SAVE);
    assign lvl1_if.we_start_hi = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP1_START_HI);
    assign lvl1_if.we_start_lo = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP1_START_LO);
    assign lvl1_if.we_end_hi   = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP1_END_HI);
    assign lvl1_if.we_end_lo   = wr_commit & (word_idx == nbrc_pkg::IDX_LOOP1_END_LO);

    // Status write, split per byte lane
    logic sw_flag_we;
    logic sw_mode_we;

    assign sw_flag_we = wr_commit & hit_status & be[1];
    assign sw_mode_we = wr_commit & hit_status & be[0];

    // Level selection and loop sequencing
    logic lvl0_running;
    logic use_lvl1;
    logic end1_hit;
    logic end0_hit;
    logic dec0;
    logic dec1;
    logic fin0;
    logic fin1;

    // In compat mode the flag alone says whether level 0 is looping
    assign lvl0_running = mode_r ? flag_r : act_r[0];
    assign use_lvl1     = ~mode_r & lvl0_running;

    assign lvl0_if.load       = rpt_start_i & ~use_lvl1;
    assign lvl1_if.load       = rpt_start_i & use_lvl1;
    assign lvl0_if.load_start = rpt_start_addr_i;
    assign lvl0_if.load_end   = rpt_end_addr_i;
    assign lvl1_if.load_start = rpt_start_addr_i;
    assign lvl1_if.load_end   = rpt_end_addr_i;

    // The inner level is checked first, so a shared end address closes it before the outer
    assign end1_hit = exec_valid_i & ~mode_r & act_r[1]
                      & (exec_addr_i == lvl1_if.end_addr);
    assign end0_hit = exec_valid_i & lvl0_running & ~end1_hit
                      & (exec_addr_i == lvl0_if.end_addr);
    assign dec1     = end1_hit & (lvl1_if.cnt != 16'h0000);
    assign fin1     = end1_hit & (lvl1_if.cnt == 16'h0000);
    assign dec0     = end0_hit & (lvl0_if.cnt != 16'h0000);
    assign fin0     = end0_hit & (lvl0_if.cnt == 16'h0000);

    assign lvl0_if.dec = dec0;
    assign lvl1_if.dec = dec1;

    nbrc_level #(
        .HAS_SAVE (1'b0)
    ) u_level0 (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .lvl       (lvl0_if.level)
    );

    nbrc_level #(
        .HAS_SAVE (1'b1)
    ) u_level1 (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .clk_en_i  (clk_en_i),
        .lvl       (lvl1_if.level)
    );

    // Loop-active flag and mode bit
    always_comb
    begin
        flag_nxt = flag_r;
        mode_nxt = mode_r;
        if (mode_r && fin0)
            flag_nxt = 1'b0;
        // In compat mode a cleared flag also drops the loop, since level 0 runs on the flag
        if (sw_flag_we)
            flag_nxt = wdata[nbrc_pkg::STAT_FLAG_BIT];
        // A new loop starting in the same cycle beats a clear
        if (mode_r && lvl0_if.load)
            flag_nxt = 1'b1;
        // Flag and mode may be written by the same access
        if (sw_mode_we)
            mode_nxt = wdata[nbrc_pkg::STAT_MODE_BIT];
    end

    // Native-mode activity and call context
    always_comb
    begin
        act_nxt = act_r;
        ctx_nxt = ctx_r;
        if (!mode_r && ctx_save_i)
        begin
            // Freeing both levels lets the subroutine start its own level 0 loop
            ctx_nxt = act_r;
            act_nxt = 2'b00;
        end
        else if (!mode_r && ctx_restore_i)
        begin
            act_nxt = ctx_restore_val_i;
        end
        if (fin1)
            act_nxt[1] = 1'b0;
        if (fin0)
            act_nxt[0] = 1'b0;
        if (lvl1_if.load)
            act_nxt[1] = 1'b1;
        if (lvl0_if.load && !mode_r)
            act_nxt[0] = 1'b1;
        if (mode_nxt)
            act_nxt = 2'b00;
    end

    // Register read mux
    always_comb
    begin
        if (word_idx == nbrc_pkg::IDX_LOOP0_CNT)
            rd_mux = lvl0_if.cnt;
        else if (word_idx == nbrc_pkg::IDX_LOOP1_CNT)
            rd_mux = lvl1_if.cnt;
        else if (word_idx == nbrc_pkg::IDX_LOOP1_SAVE)
            rd_mux = lvl1_if.save;
        else if (word_idx == nbrc_pkg::IDX_LOOP0_START_HI)
            rd_mux = {8'h00, lvl0_if.start_addr[23:16]};
        else if (word_idx == nbrc_pkg::IDX_LOOP0_START_LO)
            rd_mux = lvl0_if.start_addr[15:0];
        else if (word_idx == nbrc_pkg::IDX_LOOP0_END_HI)
            rd_mux = {8'h00, lvl0_if.end_addr[23:16]};
        else if (word_idx == nbrc_pkg::IDX_LOOP0_END_LO)
            rd_mux = lvl0_if.end_addr[15:0];
        else if (word_idx == nbrc_pkg::IDX_LOOP1_START_HI)
            rd_mux = {8'h00, lvl1_if.start_addr[23:16]};
        else if (word_idx == nbrc_pkg::IDX_LOOP1_START_LO)
            rd_mux = lvl1_if.start_addr[15:0];
        else if (word_idx == nbrc_pkg::IDX_LOOP1_END_HI)
            rd_mux = {8'h00, lvl1_if.end_addr[23:16]};
        else if (word_idx == nbrc_pkg::IDX_LOOP1_END_LO)
            rd_mux = lvl1_if.end_addr[15:0];
        else if (hit_status)
        begin
            rd_mux = 16'h0000;
            rd_mux[nbrc_pkg::STAT_FLAG_BIT] = flag_r;
            rd_mux[nbrc_pkg::STAT_MODE_BIT] = mode_r;
        end
        else if (word_idx == nbrc_pkg::IDX_LOOP_STATE)
        begin
            rd_mux = 16'h0000;
            rd_mux[nbrc_pkg::STATE_ACT_LSB +: 2] = act_r;
            rd_mux[nbrc_pkg::STATE_CTX_LSB +: 2] = ctx_r;
        end
        else
            rd_mux = 16'h0000;
    end

    // Bus handshake: one wait cycle, then a single acknowledge cycle
    always_comb
    begin
        case (bus_state_r)
            nbrc_pkg::NBRC_BUS_IDLE:
                bus_state_nxt = bus_req ? nbrc_pkg::NBRC_BUS_ACK : nbrc_pkg::NBRC_BUS_IDLE;
            nbrc_pkg::NBRC_BUS_ACK:
                bus_state_nxt = nbrc_pkg::NBRC_BUS_IDLE;
            default:
                bus_state_nxt = nbrc_pkg::NBRC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            bus_state_r <= nbrc_pkg::NBRC_BUS_IDLE;
            waitreq_r   <= 1'b1;
            rdata_r     <= nbrc_pkg::RST_RDATA;
        end
        else if (clk_en_i)
        begin
            bus_state_r <= bus_state_nxt;
            waitreq_r   <= (bus_state_nxt != nbrc_pkg::NBRC_BUS_ACK);
            if (bus_state_r == nbrc_pkg::NBRC_BUS_IDLE && avs_read_i)
                rdata_r <= {16'h0000, rd_mux};
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            flag_r <= nbrc_pkg::RST_FLAG;
            mode_r <= nbrc_pkg::RST_MODE;
            act_r  <= 2'b00;
            ctx_r  <= 2'b00;
        end
        else if (clk_en_i)
        begin
            flag_r <= flag_nxt;
            mode_r <= mode_nxt;
            act_r  <= act_nxt;
            ctx_r  <= ctx_nxt;
        end
    end

    // Fetch redirect, one cycle after the end instruction completes
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            redirect_r      <= 1'b0;
            redirect_addr_r <= nbrc_pkg::RST_ADDR;
        end
        else if (clk_en_i)
        begin
            redirect_r <= dec0 | dec1;
            if (dec1)
                redirect_addr_r <= lvl1_if.start_addr;
            else if (dec0)
                redirect_addr_r <= lvl0_if.start_addr;
        end
    end

    assign avs_readdata_o        = rdata_r;
    assign avs_waitrequest_o     = waitreq_r;
    assign redirect_o            = redirect_r;
    assign redirect_addr_o       = redirect_addr_r;
    assign level_active_o        = act_r;
    assign flow_context_record_o = ctx_r;
    assign loop_active_flag_o    = flag_r;
    assign compat_mode_bit_o     = mode_r;
endmodule : nbrc_top

// ==== include/nbrc_pkg.sv ====
// Constants, register map and types for the nested block-repeat control block
package nbrc_pkg;

    localparam int ADDR_W    = 24;
    localparam int CNT_W     = 16;
    localparam int LOC_W     = 16;
    localparam int HI_W      = 8;
    localparam int IDX_W     = 7;
    localparam int LEVELS    = 2;

    // Register indices of 16-bit locations; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LOOP0_CNT      = 7'h30;
    localparam logic [IDX_W-1:0] IDX_LOOP1_CNT      = 7'h31;
    localparam logic [IDX_W-1:0] IDX_LOOP1_SAVE     = 7'h32;
    localparam logic [IDX_W-1:0] IDX_LOOP0_END_HI   = 7'h34;
    localparam logic [IDX_W-1:0] IDX_LOOP0_END_LO   = 7'h35;
    localparam logic [IDX_W-1:0] IDX_LOOP1_START_HI = 7'h36;
    localparam logic [IDX_W-1:0] IDX_LOOP1_START_LO = 7'h37;
    localparam logic [IDX_W-1:0] IDX_LOOP1_END_HI   = 7'h38;
    localparam logic [IDX_W-1:0] IDX_LOOP1_END_LO   = 7'h39;
    localparam logic [IDX_W-1:0] IDX_LOOP0_START_HI = 7'h3c;
    localparam logic [IDX_W-1:0] IDX_LOOP0_START_LO = 7'h3d;
    localparam logic [IDX_W-1:0] IDX_STATUS_ONE     = 7'h40;
    localparam logic [IDX_W-1:0] IDX_LOOP_STATE     = 7'h41;

    // Field positions in status_reg_one
    localparam int STAT_FLAG_BIT = 15;
    localparam int STAT_MODE_BIT = 5;

    // Field positions in the loop state register
    localparam int STATE_ACT_LSB = 0;
    localparam int STATE_CTX_LSB = 4;

    // Reset values
    localparam logic              RST_FLAG  = 1'b0;
    localparam logic              RST_MODE  = 1'b1;
    localparam logic [CNT_W-1:0]  RST_CNT   = 16'h0000;
    localparam logic [ADDR_W-1:0] RST_ADDR  = 24'h000000;
    localparam logic [31:0]       RST_RDATA = 32'h0000_0000;

    typedef enum logic [0:0]
    {
        NBRC_BUS_IDLE = 1'b0,
        NBRC_BUS_ACK  = 1'b1
    } nbrc_bus_state_t;

endpackage : nbrc_pkg

// ==== include/nbrc_level_if.sv ====
// Signals between the loop controller and one loop level's resources
`timescale 1ns/100ps
interface nbrc_level_if;
    logic [1:0]  be;
    logic [15:0] wdata;
    logic        we_cnt;
    logic        we_save;
    logic        we_start_hi;
    logic        we_start_lo;
    logic        we_end_hi;
    logic        we_end_lo;
    logic        load;
    logic [23:0] load_start;
    logic [23:0] load_end;
    logic        dec;
    logic [15:0] cnt;
    logic [15:0] save;
    logic [23:0] start_addr;
    logic [23:0] end_addr;

    modport ctrl  (output be, wdata, we_cnt, we_save, we_start_hi, we_start_lo,
                   we_end_hi, we_end_lo, load, load_start, load_end, dec,
                   input cnt, save, start_addr, end_addr);
    modport level (input be, wdata, we_cnt, we_save, we_start_hi, we_start_lo,
                   we_end_hi, we_end_lo, load, load_start, load_end, dec,
                   output cnt, save, start_addr, end_addr);
endinterface : nbrc_level_if

// ==== hw/nbrc_level.sv ====
// One loop level: repeat counter, start and end address, optional counter save
`timescale 1ns/100ps
module nbrc_level #(
    parameter bit HAS_SAVE = 1'b0
) (
    input  wire logic   mclk_i,
    input  wire logic   sys_rst_i,
    input  wire logic   clk_en_i,
    nbrc_level_if.level lvl
);
    logic [nbrc_pkg::CNT_W-1:0]  cnt_r;
    logic [nbrc_pkg::CNT_W-1:0]  save_r;
    logic [nbrc_pkg::ADDR_W-1:0] start_r;
    logic [nbrc_pkg::ADDR_W-1:0] end_r;
    logic [nbrc_pkg::CNT_W-1:0]  cnt_wr;
    logic [nbrc_pkg::CNT_W-1:0]  save_wr;
    logic [nbrc_pkg::CNT_W-1:0]  start_lo_wr;
    logic [nbrc_pkg::CNT_W-1:0]  end_lo_wr;
    logic [nbrc_pkg::HI_W-1:0]   start_hi_wr;
    logic [nbrc_pkg::HI_W-1:0]   end_hi_wr;

    // Byte-lane merge of a 16-bit write
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
        merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : merge

    assign cnt_wr      = merge(cnt_r, lvl.wdata, lvl.be);
    assign save_wr     = merge(save_r, lvl.wdata, lvl.be);
    assign start_lo_wr = merge(start_r[15:0], lvl.wdata, lvl.be);
    assign end_lo_wr   = merge(end_r[15:0], lvl.wdata, lvl.be);
    // Upper byte of the high location is dropped
    assign start_hi_wr = lvl.be[0] ? lvl.wdata[7:0] : start_r[23:16];
    assign end_hi_wr   = lvl.be[0] ? lvl.wdata[7:0] : end_r[23:16];

    // Software counter write wins over a same-cycle decrement or reload; a reload wins over address writes
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_r   <= nbrc_pkg::RST_CNT;
            save_r  <= nbrc_pkg::RST_CNT;
            start_r <= nbrc_pkg::RST_ADDR;
            end_r   <= nbrc_pkg::RST_ADDR;
        end
        else if (clk_en_i)
        begin
            if (lvl.we_cnt)
                cnt_r <= cnt_wr;
            else if (lvl.load && HAS_SAVE)
                cnt_r <= save_r;
            else if (lvl.dec)
                cnt_r <= cnt_r - 16'h0001;
            if (HAS_SAVE && lvl.we_cnt)
                save_r <= cnt_wr;
            else if (HAS_SAVE && lvl.we_save)
                save_r <= save_wr;
            if (lvl.load)
                start_r <= lvl.load_start;
            else if (lvl.we_start_hi)
                start_r[23:16] <= start_hi_wr;
            else if (lvl.we_start_lo)
                start_r[15:0] <= start_lo_wr;
            if (lvl.load)
                end_r <= lvl.load_end;
            else if (lvl.we_end_hi)
                end_r[23:16] <= end_hi_wr;
            else if (lvl.we_end_lo)
                end_r[15:0] <= end_lo_wr;
        end
    end

    assign lvl.cnt        = cnt_r;
    assign lvl.save       = save_r;
    assign lvl.start_addr = start_r;
    assign lvl.end_addr   = end_r;
endmodule : nbrc_level

// ==== verif/nbrc_props.sv ====
// Port assertions for the nested block-repeat control block
`timescale 1ns/100ps
module nbrc_props (
    input wire logic       mclk_i,
    input wire logic       sys_rst_i,
    input wire logic       clk_en_i,
    input wire logic       avs_write_i,
    input wire logic       rpt_start_i,
    input wire logic       exec_valid_i,
    input wire logic       ctx_save_i,
    input wire logic       ctx_restore_i,
    input wire logic [1:0] ctx_restore_val_i,
    input wire logic       redirect_o,
    input wire logic [1:0] level_active_o,
    input wire logic [1:0] flow_context_record_o,
    input wire logic       loop_active_flag_o,
    input wire logic       compat_mode_bit_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_flag_set;
        clk_en_i && rpt_start_i && compat_mode_bit_o |=> loop_active_flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    // Only a loop end or a software write may drop the flag
    property p_flag_hold;
        loop_active_flag_o && !avs_write_i && !exec_valid_i |=> loop_active_flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_flag_rise;
        $rose(loop_active_flag_o) |-> $past(rpt_start_i) || $past(avs_write_i);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag without cause");
    property p_compat_lvl;
        compat_mode_bit_o |-> level_active_o == 2'b00;
    endproperty
    a_compat_lvl: assert property (p_compat_lvl) else $error("level used in compat");
    property p_nest;
        clk_en_i && rpt_start_i && !compat_mode_bit_o && level_active_o[0] |=> level_active_o == 2'b11;
    endproperty
    a_nest: assert property (p_nest) else $error("inner level not used");
    property p_ctx_save;
        clk_en_i && ctx_save_i && !compat_mode_bit_o
            |=> flow_context_record_o == $past(level_active_o) && level_active_o == 2'b00;
    endproperty
    a_ctx_save: assert property (p_ctx_save) else $error("context not recorded");
    property p_ctx_rest;
        clk_en_i && ctx_restore_i && !compat_mode_bit_o |=> level_active_o == $past(ctx_restore_val_i);
    endproperty
    a_ctx_rest: assert property (p_ctx_rest) else $error("context not restored");
    property p_redir;
        redirect_o |-> $past(exec_valid_i) && $past(clk_en_i);
    endproperty
    a_redir: assert property (p_redir) else $error("redirect without retire");
endmodule : nbrc_props

bind nbrc_top nbrc_props u_props (.mclk_i, .sys_rst_i, .clk_en_i, .avs_write_i, .rpt_start_i,
    .exec_valid_i, .ctx_save_i, .ctx_restore_i, .ctx_restore_val_i, .redirect_o,
    .level_active_o, .flow_context_record_o, .loop_active_flag_o, .compat_mode_bit_o);

// ==== verif/nbrc_cpu_model.sv ====
// CPU flow partner: repeat starts, instruction retirements, call and return events
`timescale 1ns/100ps
module nbrc_cpu_model (
    input  wire logic   mclk_i,
    output logic        rpt_start_o = 1'b0,
    output logic [23:0] rpt_start_addr_o = 24'h000000,
    output logic [23:0] rpt_end_addr_o = 24'h000000,
    output logic        exec_valid_o = 1'b0,
    output logic [23:0] exec_addr_o = 24'h000000,
    output logic        ctx_save_o = 1'b0,
    output logic        ctx_restore_o = 1'b0,
    output logic [1:0]  ctx_restore_val_o = 2'h0
);
    // Stale addresses and data are inverted so a late sample cannot pass by luck
    task automatic start_loop(input logic [23:0] s, input logic [23:0] e);
        @(posedge mclk_i);
        rpt_start_o      <= 1'b1;
        rpt_start_addr_o <= s;
        rpt_end_addr_o   <= e;
        @(posedge mclk_i);
        rpt_start_o      <= 1'b0;
        rpt_start_addr_o <= ~s;
        rpt_end_addr_o   <= ~e;
    endtask : start_loop
    // Callers issue no counter writes near a loop's last instructions
    task automatic exec_at(input logic [23:0] a);
        @(posedge mclk_i);
        exec_valid_o <= 1'b1;
        exec_addr_o  <= a;
        @(posedge mclk_i);
        exec_valid_o <= 1'b0;
        exec_addr_o  <= ~a;
    endtask : exec_at
    task automatic ctx(input logic save, input logic [1:0] v);
        @(posedge mclk_i);
        ctx_save_o        <= save;
        ctx_restore_o     <= ~save;
        ctx_restore_val_o <= v;
        @(posedge mclk_i);
        ctx_save_o        <= 1'b0;
        ctx_restore_o     <= 1'b0;
        ctx_restore_val_o <= ~v;
    endtask : ctx
endmodule : nbrc_cpu_model

// ==== verif/tb_nested_block_repeat_control.sv ====
// Bench: register map, compat and native loops, call context
`timescale 1ns/100ps
module tb_nested_block_repeat_control;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        clk_en_i = 1'b1;
    logic [8:0]  avs_address_i = 9'h000;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'h3;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o, rpt_start_i, exec_valid_i, ctx_save_i, ctx_restore_i;
    logic [23:0] rpt_start_addr_i, rpt_end_addr_i, exec_addr_i, redirect_addr_o;
    logic [1:0]  ctx_restore_val_i, level_active_o, flow_context_record_o;
    logic        redirect_o, loop_active_flag_o, compat_mode_bit_o;
    logic [23:0] last_redir = 24'h000000;
    logic [15:0] q;
    int          fails = 0;
    int          n_checks = 0;
    int          n_redir = 0;

    nbrc_top dut (.mclk_i, .sys_rst_i, .clk_en_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .rpt_start_i,
        .rpt_start_addr_i, .rpt_end_addr_i, .exec_valid_i, .exec_addr_i, .ctx_save_i,
        .ctx_restore_i, .ctx_restore_val_i, .redirect_o, .redirect_addr_o, .level_active_o,
        .flow_context_record_o, .loop_active_flag_o, .compat_mode_bit_o);
    nbrc_cpu_model cpu (.mclk_i, .rpt_start_o(rpt_start_i), .rpt_start_addr_o(rpt_start_addr_i),
        .rpt_end_addr_o(rpt_end_addr_i), .exec_valid_o(exec_valid_i), .exec_addr_o(exec_addr_i),
        .ctx_save_o(ctx_save_i), .ctx_restore_o(ctx_restore_i),
        .ctx_restore_val_o(ctx_restore_val_i));

    always #4 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
    begin
        if (redirect_o === 1'b1)
        begin
            n_redir++;
            last_redir = redirect_addr_o;
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One Avalon access; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [6:0] idx, input logic [15:0] d);
        int i;
        i = 0;
        @(posedge mclk_i);
        avs_address_i   <= {idx, 2'b00};
        avs_writedata_i <= {16'h0000, d};
        avs_write_i     <= w;
        avs_read_i      <= ~w;
        do
        begin
            @(posedge mclk_i);
            i++;
        end
        while (avs_waitrequest_o !== 1'b0 && i < 20);
        if (avs_waitrequest_o !== 1'b0)
        begin
            fails++;
            finish_test();
        end
        else
        begin
            q = avs_readdata_o[15:0];
            avs_write_i <= 1'b0;
            avs_read_i  <= 1'b0;
        end
    endtask : bus
    task automatic rd(input logic [6:0] idx, input logic [15:0] exp, input string nm);
        bus(1'b0, idx, 16'h0000);
        chk(nm, {8'h00, q}, {8'h00, exp});
    endtask : rd

    initial
    begin
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rd(nbrc_pkg::IDX_STATUS_ONE, 16'h0020, "status reset");
        bus(1'b1, 7'h10, 16'hbeef);
        rd(7'h10, 16'h0000, "unmapped");
        bus(1'b1, 7'h3c, 16'habcd);
        rd(7'h3c, 16'h00cd, "start0 high");
        bus(1'b1, 7'h3d, 16'h1234);
        rd(nbrc_pkg::IDX_LOOP0_START_LO, 16'h1234, "start0 low");
        $display("test register map done");
        bus(1'b1, nbrc_pkg::IDX_LOOP0_CNT, 16'h0002);
        cpu.start_loop(24'h000100, 24'h000104);
        @(negedge mclk_i);
        chk("flag set", {23'h0, loop_active_flag_o}, 24'h1);
        chk("compat levels", {22'h0, level_active_o}, 24'h0);
        repeat (3) cpu.exec_at(24'h000104);
        repeat (2) @(posedge mclk_i);
        chk("redirects", 24'(n_redir), 24'h2);
        chk("target", last_redir, 24'h000100);
        chk("flag end", {23'h0, loop_active_flag_o}, 24'h0);
        rd(nbrc_pkg::IDX_LOOP0_END_LO, 16'h0104, "end0 loaded");
        $display("test compat loop done");
        n_redir = 0;
        bus(1'b1, nbrc_pkg::IDX_LOOP0_CNT, 16'h0005);
        cpu.start_loop(24'h000100, 24'h000104);
        bus(1'b1, nbrc_pkg::IDX_STATUS_ONE, 16'h0020);
        cpu.exec_at(24'h000104);
        repeat (2) @(posedge mclk_i);
        chk("stopped loop", 24'(n_redir), 24'h0);
        cpu.start_loop(24'h000100, 24'h000104);
        bus(1'b1, nbrc_pkg::IDX_STATUS_ONE, 16'h0000);
        rd(nbrc_pkg::IDX_STATUS_ONE, 16'h0000, "mode switch");
        $display("test mode switch done");
        bus(1'b1, nbrc_pkg::IDX_LOOP1_CNT, 16'h0001);
        rd(nbrc_pkg::IDX_LOOP1_SAVE, 16'h0001, "save load");
        bus(1'b1, nbrc_pkg::IDX_LOOP0_CNT, 16'h0001);
        cpu.start_loop(24'h000200, 24'h000210);
        cpu.start_loop(24'h000204, 24'h000208);
        @(negedge mclk_i);
        chk("nested", {22'h0, level_active_o}, 24'h3);
        cpu.exec_at(24'h000208);
        repeat (2) @(posedge mclk_i);
        chk("inner target", last_redir, 24'h000204);
        rd(nbrc_pkg::IDX_LOOP1_CNT, 16'h0000, "inner count");
        rd(nbrc_pkg::IDX_LOOP1_SAVE, 16'h0001, "save kept");
        cpu.exec_at(24'h000208);
        cpu.start_loop(24'h000204, 24'h000208);
        rd(nbrc_pkg::IDX_LOOP1_CNT, 16'h0001, "inner reload");
        cpu.ctx(1'b1, 2'b00);
        @(negedge mclk_i);
        chk("context", {22'h0, flow_context_record_o}, 24'h3);
        cpu.ctx(1'b0, 2'b01);
        @(negedge mclk_i);
        chk("restored", {22'h0, level_active_o}, 24'h1);
        cpu.exec_at(24'h000210);
        repeat (2) @(posedge mclk_i);
        chk("outer target", last_redir, 24'h000200);
        clk_en_i <= 1'b0;
        cpu.exec_at(24'h000210);
        clk_en_i <= 1'b1;
        rd(nbrc_pkg::IDX_LOOP_STATE, 16'h0031, "frozen state");
        $display("test native nesting done");
        finish_test();
    end
endmodule : tb_nested_block_repeat_control
